// File: tsv_pkg.sv
// package: constants for the transfer server mode decode and source pointer handling
package tsv_pkg;
  // ------------------------------------------------------------
  // control word fields
  // ------------------------------------------------------------
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam int CTL_INC_BIT = 1;
  localparam int CTL_UPD_BIT = 3;
  localparam logic [2:0] MODE_BLOCK = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h4;
  localparam logic [2:0] MODE_TOUT = 3'h1;
  localparam logic [2:0] MODE_TIN = 3'h3;
  localparam logic [2:0] MODE_SCAN = 3'h6;
  // ------------------------------------------------------------
  // control block layout
  // ------------------------------------------------------------
  localparam logic [2:0] CB_OFS_BLOCK_COUNT = 3'h6;
  localparam logic [2:0] CB_OFS_SOURCE = 3'h2;
  localparam logic [15:0] SRC_RESET = 16'h0000;
  localparam logic [7:0] CNT_RESET = 8'h00;
  typedef enum logic [2:0] {TSV_NONE, TSV_BLOCK, TSV_SINGLE, TSV_TOUT, TSV_TIN, TSV_SCAN} tsv_mode_t;
endpackage : tsv_pkg

// File: tsv_mode_dec.sv
// mode field decoder for the transfer server control word
`timescale 1ns/1ps
module tsv_mode_dec (
  input wire logic [7:0] i_ctl,
  output tsv_pkg::tsv_mode_t o_mode,
  output logic o_uses_src
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic [2:0] mode_bits = i_ctl[tsv_pkg::MODE_HI:tsv_pkg::MODE_LO];
  always_comb begin
    unique case (mode_bits)
      tsv_pkg::MODE_BLOCK: o_mode = tsv_pkg::TSV_BLOCK;
      tsv_pkg::MODE_SINGLE: o_mode = tsv_pkg::TSV_SINGLE;
      tsv_pkg::MODE_TOUT: o_mode = tsv_pkg::TSV_TOUT;
      tsv_pkg::MODE_TIN: o_mode = tsv_pkg::TSV_TIN;
      tsv_pkg::MODE_SCAN: o_mode = tsv_pkg::TSV_SCAN;
      default: o_mode = tsv_pkg::TSV_NONE;
    endcase
  end
  // only these modes read memory through the source pointer
  assign o_uses_src = (o_mode == tsv_pkg::TSV_BLOCK) || (o_mode == tsv_pkg::TSV_SINGLE) ||
                      (o_mode == tsv_pkg::TSV_TOUT);
endmodule : tsv_mode_dec

// File: tsv_server.sv
// transfer server cycle engine: control block load, mode decode, source pointer sequencing
//
// Operation
// - control word bits 7..5 equal to 000 select block transfer and 100 select single transfer.
// - mode pattern 001 is timed-output, 011 is timed-input and 110 is converter-scan.
// - the block count is fetched from byte offset 6 of the control block, never offset 7.
// - the source pointer is used only in single, block and timed-output modes, as the read address.
// - the source pointer addresses the source location and may be incremented when a cycle ends.
// - in single transfer, control bits 1 and 3 decide whether the source pointer is incremented.
// - in block transfer, bit 1 set increments the pointer after each transfer, clear leaves it.
// - at the end of a block, bit 3 chooses keeping the final pointer or restoring the starting one.
// - in timed-output mode the pointer is updated at cycle end only when bit 3 requests it.
`timescale 1ns/1ps
module tsv_server #(
  parameter int ADDR_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [7:0] i_ctl,
  input wire logic [ADDR_W-1:0] i_cb_base,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_req,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [ADDR_W-1:0] o_src_ptr,
  output logic [2:0] o_mode,
  output logic o_busy,
  output logic o_done,
  output logic o_wb_req
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("tsv_server supports a 16-bit address only");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_CNT, ST_SRCL, ST_SRCH, ST_XFER, ST_END} tsv_st_t;
  tsv_st_t st_r, st_nxt;
  tsv_pkg::tsv_mode_t dec_mode, mode_r;
  logic uses_src;
  // source use is latched with the start so a later change of i_ctl cannot redirect the cycle
  logic src_mode_r;
  logic [7:0] ctl_r;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] src_r, src_nxt, save_r, save_nxt;
  logic [15:0] addr_nxt;
  logic req_nxt, done_nxt, wb_nxt;

  tsv_mode_dec u_dec (
    .i_ctl(i_ctl),
    .o_mode(dec_mode),
    .o_uses_src(uses_src)
  );

  // ------------------------------------------------------------
  // pointer policy
  // ------------------------------------------------------------
  wire logic inc_bit = ctl_r[tsv_pkg::CTL_INC_BIT];
  wire logic upd_bit = ctl_r[tsv_pkg::CTL_UPD_BIT];
  wire logic is_block = (mode_r == tsv_pkg::TSV_BLOCK);
  // single transfer: both bits must be set before the pointer moves
  wire logic single_inc = inc_bit & upd_bit;
  wire logic step_inc = is_block ? inc_bit : 1'b0;
  wire logic end_inc = (mode_r == tsv_pkg::TSV_SINGLE) ? single_inc :
                       (mode_r == tsv_pkg::TSV_TOUT) ? upd_bit : 1'b0;
  // block end: bit 3 set keeps the final value, clear restores the saved start
  wire logic [15:0] block_end_src = upd_bit ? src_r : save_r;
  wire logic last_xfer = (cnt_r <= 8'h01);
  wire logic [15:0] src_step = src_r + 16'h0001;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    src_nxt = src_r;
    save_nxt = save_r;
    addr_nxt = o_mem_addr;
    req_nxt = o_mem_req;
    done_nxt = 1'b0;
    wb_nxt = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (i_start) begin
          addr_nxt = i_cb_base + {13'h0000, tsv_pkg::CB_OFS_BLOCK_COUNT};
          req_nxt = 1'b1;
          st_nxt = ST_CNT;
        end
      end
      ST_CNT: begin
        if (i_mem_ack) begin
          cnt_nxt = i_mem_rdata;
          addr_nxt = i_cb_base + {13'h0000, tsv_pkg::CB_OFS_SOURCE};
          req_nxt = src_mode_r;
          st_nxt = src_mode_r ? ST_SRCL : ST_END;
        end
      end
      ST_SRCL: begin
        if (i_mem_ack) begin
          src_nxt[7:0] = i_mem_rdata;
          addr_nxt = o_mem_addr + 16'h0001;
          st_nxt = ST_SRCH;
        end
      end
      ST_SRCH: begin
        if (i_mem_ack) begin
          src_nxt[15:8] = i_mem_rdata;
          save_nxt = {i_mem_rdata, src_r[7:0]};
          addr_nxt = {i_mem_rdata, src_r[7:0]};
          st_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        if (i_mem_ack) begin
          if (is_block && !last_xfer) begin
            cnt_nxt = cnt_r - 8'h01;
            src_nxt = step_inc ? src_step : src_r;
            addr_nxt = step_inc ? src_step : src_r;
          end else begin
            req_nxt = 1'b0;
            cnt_nxt = is_block ? 8'h00 : cnt_r;
            if (is_block) begin
              src_nxt = step_inc ? block_end_src_after(upd_bit, src_step, save_r) : block_end_src;
            end else begin
              src_nxt = end_inc ? src_step : src_r;
            end
            st_nxt = ST_END;
          end
        end
      end
      ST_END: begin
        req_nxt = 1'b0;
        done_nxt = 1'b1;
        wb_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // final block pointer including the increment of the last transfer
  function automatic logic [15:0] block_end_src_after(input logic keep, input logic [15:0] stepped,
                                                      input logic [15:0] saved);
    block_end_src_after = keep ? stepped : saved;
  endfunction : block_end_src_after

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= ST_IDLE;
      mode_r <= tsv_pkg::TSV_NONE;
      src_mode_r <= 1'b0;
      ctl_r <= 8'h00;
      cnt_r <= tsv_pkg::CNT_RESET;
      src_r <= tsv_pkg::SRC_RESET;
      save_r <= tsv_pkg::SRC_RESET;
      o_mem_addr <= 16'h0000;
      o_mem_req <= 1'b0;
      o_done <= 1'b0;
      o_wb_req <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      if (st_r == ST_IDLE && i_start) begin
        mode_r <= dec_mode;
        src_mode_r <= uses_src;
        ctl_r <= i_ctl;
      end
      cnt_r <= cnt_nxt;
      src_r <= src_nxt;
      save_r <= save_nxt;
      o_mem_addr <= addr_nxt;
      o_mem_req <= req_nxt;
      o_done <= done_nxt;
      o_wb_req <= wb_nxt;
    end
  end

  // ------------------------------------------------------------
  // mirrored outputs, registered
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_src_ptr <= 16'h0000;
      o_mode <= 3'h0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_src_ptr <= src_nxt;
      o_mode <= (st_r == ST_IDLE && i_start) ? dec_mode : mode_r;
      o_busy <= (st_nxt != ST_IDLE);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_count_offset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_IDLE && i_start) |=> (o_mem_addr == $past(i_cb_base) + 16'h0006))
    else $error("block count not fetched from offset 6");
  a_block_decode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_IDLE && i_start && i_ctl[7:5] == 3'h0) |=> (mode_r == tsv_pkg::TSV_BLOCK))
    else $error("pattern 000 not decoded as block");
  a_single_decode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_IDLE && i_start && i_ctl[7:5] == 3'h4) |=> (mode_r == tsv_pkg::TSV_SINGLE))
    else $error("pattern 100 not decoded as single");
  a_other_decode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_IDLE && i_start && i_ctl[7:5] == 3'h6) |=> (mode_r == tsv_pkg::TSV_SCAN))
    else $error("pattern 110 not decoded as scan");
  a_no_src_use: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st_r == ST_CNT && i_ce && i_mem_ack && !src_mode_r) |=> (st_r == ST_END && !o_mem_req))
    else $error("source pointer fetched in a mode without it");
  a_block_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_XFER && is_block && !inc_bit && i_mem_ack && !last_xfer) |=> $stable(src_r))
    else $error("block pointer moved with bit 1 clear");
  a_block_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_XFER && is_block && inc_bit && i_mem_ack && !last_xfer) |=> (src_r == $past(src_r) + 16'h0001))
    else $error("block pointer did not step");
  a_block_restore: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_XFER && is_block && !upd_bit && i_mem_ack && last_xfer) |=> (src_r == save_r))
    else $error("block pointer not restored");
  a_tout_update: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_XFER && mode_r == tsv_pkg::TSV_TOUT && i_mem_ack) |=>
    (src_r == $past(src_r) + {15'h0000, $past(upd_bit)}))
    else $error("timed-output pointer update wrong");
  a_single_update: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st_r == ST_XFER && mode_r == tsv_pkg::TSV_SINGLE && i_mem_ack) |=>
    (src_r == $past(src_r) + {15'h0000, $past(single_inc)}))
    else $error("single pointer update wrong");
endmodule : tsv_server

// File: tsv_mem_model.sv
// memory partner model: byte memory answering the server's read requests
`timescale 1ns/1ps
module tsv_mem_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_r;
  // ----------------------------------------
  // read answer, prompt or slow
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack <= 1'b0;
      o_rdata <= 8'h00;
      wait_r <= 4'h0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      // bus released: never leave the old byte showing
      o_rdata <= ~o_rdata;
      wait_r <= 4'h0;
    end else if (i_req && wait_r >= i_delay) begin
      o_ack <= 1'b1;
      o_rdata <= mem[i_addr[7:0]];
    end else if (i_req) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : tsv_mem_model

// File: test_tsv_server.sv
// self-checking testbench for the transfer server
`timescale 1ns/1ps
module test_tsv_server;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_start = 1'b0;
  logic [7:0] i_ctl = 8'h00;
  logic [15:0] i_cb_base = 16'h0040;
  logic [3:0] delay = 4'h0;
  logic mem_ack;
  logic [7:0] mem_rdata;
  logic o_mem_req, o_busy, o_done, o_wb_req;
  logic [15:0] o_mem_addr, o_src_ptr;
  logic [2:0] o_mode;
  int fail_count = 0;
  int n_checks = 0;
  logic [15:0] seen [$];
  always #2.5 i_clk = ~i_clk;
  tsv_server #(.ADDR_W(16)) i_tsv_server (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_start(i_start),
    .i_ctl(i_ctl), .i_cb_base(i_cb_base), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .o_src_ptr(o_src_ptr), .o_mode(o_mode), .o_busy(o_busy), .o_done(o_done),
    .o_wb_req(o_wb_req));
  tsv_mem_model i_tsv_mem_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .i_delay(delay), .o_ack(mem_ack), .o_rdata(mem_rdata));
  // ----------------------------------------
  // read address monitor
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (mem_ack === 1'b1 && o_mem_req === 1'b1) begin
      seen.push_back(o_mem_addr);
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one server cycle; reads hold count, source pair, then transfers
  task automatic run(input logic [7:0] ctl, input logic [15:0] src, input logic [7:0] cnt, input int n_reads,
                     input int inc, input logic [2:0] mode, input logic [15:0] exp_ptr);
    int k;
    logic [15:0] exp_a;
    seen.delete();
    i_tsv_mem_model.mem[8'h46] = cnt;
    i_tsv_mem_model.mem[8'h42] = src[7:0];
    i_tsv_mem_model.mem[8'h43] = src[15:8];
    @(negedge i_clk);
    i_ctl = ctl;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    check("mode", {13'h0000, mode}, {13'h0000, o_mode});
    check("busy", 16'h0001, {15'h0000, o_busy});
    k = 0;
    while (o_done !== 1'b1 && k < 300) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check("wb_req", 16'h0001, {15'h0000, o_wb_req});
    check("busy_end", 16'h0000, {15'h0000, o_busy});
    check("req_end", 16'h0000, {15'h0000, o_mem_req});
    if (n_reads > 1) begin
      check("src_ptr", exp_ptr, o_src_ptr);
    end
    check("reads", 16'(n_reads), 16'(seen.size()));
    for (int j = 0; j < seen.size() && j < n_reads; j++) begin
      exp_a = (j == 0) ? i_cb_base + 16'h0006 : (j < 3) ? i_cb_base + 16'(j + 1) : src + 16'(inc * (j - 3));
      check("read_addr", exp_a, seen[j]);
    end
    @(negedge i_clk);
  endtask : run
  task automatic t_block();
    run(8'h0A, 16'h1280, 8'h03, 6, 1, tsv_pkg::TSV_BLOCK, 16'h1283);
    delay = 4'h3;
    run(8'h02, 16'h12FE, 8'h04, 7, 1, tsv_pkg::TSV_BLOCK, 16'h12FE);
    delay = 4'h0;
    run(8'h08, 16'h1280, 8'h00, 4, 0, tsv_pkg::TSV_BLOCK, 16'h1280);
  endtask : t_block
  task automatic t_single();
    for (int i = 0; i < 4; i++) begin
      run(8'h80 | (i[0] ? 8'h02 : 8'h00) | (i[1] ? 8'h08 : 8'h00), 16'h3470, 8'h05, 4, 0,
          tsv_pkg::TSV_SINGLE, 16'h3470 + 16'(i == 3));
    end
  endtask : t_single
  task automatic t_tout();
    for (int i = 0; i < 2; i++) begin
      run(8'h22 | (i[0] ? 8'h08 : 8'h00), 16'h5610, 8'h02, 4, 0, tsv_pkg::TSV_TOUT, 16'h5610 + 16'(i));
    end
  endtask : t_tout
  task automatic t_tin_scan();
    run(8'h6A, 16'h7890, 8'h02, 1, 0, tsv_pkg::TSV_TIN, 16'h0000);
    run(8'hCA, 16'h7890, 8'h02, 1, 0, tsv_pkg::TSV_SCAN, 16'h0000);
    run(8'h40, 16'h7890, 8'h02, 1, 0, tsv_pkg::TSV_NONE, 16'h0000);
  endtask : t_tin_scan
  // reset in the middle of a block cycle, then release and check the server stays idle
  task automatic t_reset();
    @(negedge i_clk);
    i_ctl = 8'h0A;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b0;
    @(negedge i_clk);
    check("rst_req", 16'h0000, {15'h0000, o_mem_req});
    check("rst_busy", 16'h0000, {15'h0000, o_busy});
    check("rst_src", 16'h0000, o_src_ptr);
    check("rst_mode", 16'h0000, {13'h0000, o_mode});
    i_rst_b = 1'b1;
    repeat (2) @(negedge i_clk);
    check("rel_busy", 16'h0000, {15'h0000, o_busy});
    check("rel_done", 16'h0000, {15'h0000, o_done});
  endtask : t_reset
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst_b = 1'b1;
    t_block();
    t_reset();
    t_single();
    t_tout();
    t_tin_scan();
    test_done();
  end
  // well under a thousand cycles suffice; this cuts a hang after 10000 cycles
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
endmodule : test_tsv_server
